// ---- src/valve_consts.svh ----
// Constants for the valve actuation priority block
`ifndef VALVE_CONSTS_SVH
`define VALVE_CONSTS_SVH
`define NS_CMD_COUNT      14
`define DIV_COUNT         2
`define MOD_COUNT         2
`define REG_CTRL          32'h0000_0000
`define REG_STATUS        32'h0000_0004
`define REG_NSCMD         32'h0000_0008
`define REG_FORCE         32'h0000_000C
`define CTRL_RESET_VAL    32'h0000_0000
`define CTRL_BIT_OPEN_REQ 0
`define CTRL_BIT_MOD_EN0  1
`define CTRL_BIT_MOD_EN1  2
`define NS_BIT_OPEN       0
`define NS_BIT_CLOSE      1
`define HTRANS_NONSEQ_BIT 1
`endif

// ---- src/valve_pkg.sv ----
// Types for the valve actuation priority block
package valve_pkg;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_SEALED = 3'b010,
    ST_RELEASE = 3'b100
  } seal_state_e;
endpackage : valve_pkg

// ---- src/input_sync.sv ----
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s st_ff;
  sync_s nxt_st;

  always_comb begin
    nxt_st.stage1 = din;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.stage2;
endmodule : input_sync
`default_nettype wire

// ---- src/valve_actuation_priority.sv ----
// Actuation priority logic for one safety valve with AHB-Lite registers
// Behaviour
// - Protective demand is latched in a seal-in state until completed.
// - Seal-in clears only after feedback shows the valve at demanded position.
// - Protective actuation de-energizes solenoid outputs; no drive means safe.
// - Valve command closed whenever either division solenoid is de-energized.
// - Valve open command only when both division solenoids are energized.
// - Solenoid energized to open; either redundant module may supply drive.
// - Solenoid de-energized only when both redundant module outputs are off.
// - Each division has exactly one nonsafety enable input from one switch.
// - The division enable applies to all safety component outputs at once.
// - Nonsafety commands arrive on 14 separate hardwired discrete inputs.
// - Valve logic duplicated per module; one remaining module stays functional.
`timescale 1ns/10ps
`default_nettype none
`include "valve_consts.svh"
module valve_actuation_priority (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output var  logic [31:0]               hrdata,
  output var  logic                      hreadyout,
  output var  logic                      hresp,
  input  wire logic [`DIV_COUNT-1:0]     protective_demand,
  input  wire logic [`DIV_COUNT-1:0]     nonsafety_enable,
  input  wire logic [`NS_CMD_COUNT-1:0]  nonsafety_cmd,
  input  wire logic [`DIV_COUNT-1:0]     pos_closed_fb,
  output var  logic [`DIV_COUNT*`MOD_COUNT-1:0] module_drive,
  output var  logic [`DIV_COUNT-1:0]     solenoid_energized,
  output var  logic                      valve_open_cmd,
  output var  logic [`DIV_COUNT-1:0]     seal_in_active
);
  localparam int PIN_W = 2*`DIV_COUNT + `NS_CMD_COUNT + `DIV_COUNT;

  typedef struct packed {
    logic                              bus_pend;
    logic                              bus_wr;
    logic [3:0]                        bus_addr;
    logic [31:0]                       ctrl;
    logic [31:0]                       rdata;
    valve_pkg::seal_state_e [`DIV_COUNT-1:0] seal;
    logic [`DIV_COUNT*`MOD_COUNT-1:0]  drive;
    logic [`DIV_COUNT-1:0]             sol;
    logic                              open;
    logic [`DIV_COUNT-1:0]             sealed;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic [PIN_W-1:0]              pins_sync;
  logic [`DIV_COUNT-1:0]         dem_s;
  logic [`DIV_COUNT-1:0]         ens_s;
  logic [`NS_CMD_COUNT-1:0]      cmd_s;
  logic [`DIV_COUNT-1:0]         fb_s;

  // All field pins pass two flip-flops before use
  input_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({protective_demand, nonsafety_enable, nonsafety_cmd, pos_closed_fb}),
    .dout    (pins_sync)
  );

  assign {dem_s, ens_s, cmd_s, fb_s} = pins_sync;

  logic                      bus_take;
  logic [`DIV_COUNT-1:0]     ns_open;
  logic [`DIV_COUNT-1:0]     ns_close;
  logic [`DIV_COUNT-1:0]     trip;
  logic [`DIV_COUNT*`MOD_COUNT-1:0] mod_in_service;

  assign bus_take = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

  always_comb begin
    nxt_st = st_ff;
    ns_open = '0;
    ns_close = '0;
    trip = '0;
    mod_in_service = '0;

    // Bus slave: zero wait states, data phase one cycle after address
    nxt_st.bus_pend = bus_take;
    if (bus_take) begin
      nxt_st.bus_wr = hwrite;
      nxt_st.bus_addr = haddr[3:0];
    end
    if (st_ff.bus_pend && st_ff.bus_wr && ({28'h0000000, st_ff.bus_addr} == `REG_CTRL)) begin
      nxt_st.ctrl = hwdata;
    end
    if (bus_take && !hwrite) begin
      case ({28'h0000000, haddr[3:0]})
        `REG_CTRL:   nxt_st.rdata = st_ff.ctrl;
        `REG_STATUS: nxt_st.rdata = {23'h000000, st_ff.open, st_ff.sol, st_ff.sealed, st_ff.drive};
        `REG_NSCMD:  nxt_st.rdata = {16'h0000, ens_s, cmd_s};
        `REG_FORCE:  nxt_st.rdata = {28'h0000000, fb_s, dem_s};
        default:     nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    for (int d = 0; d < `DIV_COUNT; d++) begin
      // One enable per division gates the open and close commands at once; the CTRL open request bypasses it
      ns_open[d]  = ens_s[d] && cmd_s[`NS_BIT_OPEN];
      ns_close[d] = ens_s[d] && cmd_s[`NS_BIT_CLOSE];

      case (st_ff.seal[d])
        valve_pkg::ST_NORMAL: begin
          if (dem_s[d]) begin
            nxt_st.seal[d] = valve_pkg::ST_SEALED;
          end
        end
        valve_pkg::ST_SEALED: begin
          // Held even if the demand drops, until position reached
          if (fb_s[d]) begin
            nxt_st.seal[d] = valve_pkg::ST_RELEASE;
          end
        end
        valve_pkg::ST_RELEASE: begin
          if (dem_s[d]) begin
            nxt_st.seal[d] = valve_pkg::ST_SEALED;
          end else begin
            nxt_st.seal[d] = valve_pkg::ST_NORMAL;
          end
        end
        default: nxt_st.seal[d] = valve_pkg::ST_SEALED;
      endcase

      // Seal-in or live demand wins over nonsafety open
      trip[d] = dem_s[d] || (st_ff.seal[d] == valve_pkg::ST_SEALED) || ns_close[d];

      for (int m = 0; m < `MOD_COUNT; m++) begin
        mod_in_service[d*`MOD_COUNT+m] = st_ff.ctrl[`CTRL_BIT_MOD_EN0+m] == 1'b0;
        // Each module runs identical logic; removed module drops drive
        nxt_st.drive[d*`MOD_COUNT+m] = mod_in_service[d*`MOD_COUNT+m] && !trip[d] &&
          (ns_open[d] || st_ff.ctrl[`CTRL_BIT_OPEN_REQ] || st_ff.sol[d]);
      end
      // Solenoid energized by either module, off only when both off
      nxt_st.sol[d] = |st_ff.drive[d*`MOD_COUNT +: `MOD_COUNT];
      nxt_st.sealed[d] = st_ff.seal[d] == valve_pkg::ST_SEALED;
    end
    // Open only with both divisions energized; any one off closes
    nxt_st.open = &st_ff.sol;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.bus_pend <= 1'b0;
      st_ff.bus_wr <= 1'b0;
      st_ff.bus_addr <= 4'h0;
      st_ff.ctrl <= `CTRL_RESET_VAL;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.seal <= '{default: valve_pkg::ST_NORMAL};
      st_ff.drive <= '0;
      st_ff.sol <= '0;
      st_ff.open <= 1'b0;
      st_ff.sealed <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = st_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign module_drive = st_ff.drive;
  assign solenoid_energized = st_ff.sol;
  assign valve_open_cmd = st_ff.open;
  assign seal_in_active = st_ff.sealed;
endmodule : valve_actuation_priority
`default_nettype wire

// ---- verification/valve_actuation_priority_assertions.sv ----
// Assertions for the valve actuation priority block
`timescale 1ns/10ps
`default_nettype none
module valve_actuation_priority_assertions (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [1:0] protective_demand,
  input wire logic [1:0] pos_closed_fb,
  input wire logic [3:0] module_drive,
  input wire logic [1:0] solenoid_energized,
  input wire logic       valve_open_cmd,
  input wire logic [1:0] seal_in_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_open_both: assert property (valve_open_cmd |-> $past(&solenoid_energized))
    else $error("open without both solenoids");
  a_close_either: assert property (!(&solenoid_energized) |=> !valve_open_cmd)
    else $error("open with a solenoid off");
  a_sol_on: assert property (|module_drive[1:0] |=> solenoid_energized[0])
    else $error("solenoid off with drive");
  a_sol_off: assert property (!solenoid_energized[0] |-> $past(module_drive[1:0]) == 2'h0)
    else $error("solenoid off with drive");
  a_trip_drop: assert property ($rose(seal_in_active[0]) |-> module_drive[1:0] == 2'h0)
    else $error("sealed while driven");
  a_seal_hold: assert property ((!pos_closed_fb[0])[*6] ##0 seal_in_active[0] |=> seal_in_active[0])
    else $error("seal lost without feedback");
  a_seal_free: assert property ($rose(pos_closed_fb[0]) && seal_in_active[0] |-> ##[1:8] !seal_in_active[0])
    else $error("seal not released");
  a_demand_wins: assert property (protective_demand[0] |-> ##3 module_drive[1:0] == 2'h0)
    else $error("drive kept under demand");
  cover property (seal_in_active[0] ##1 !seal_in_active[0]);
  cover property (valve_open_cmd);
  cover property (module_drive == 4'hA);
endmodule : valve_actuation_priority_assertions
bind valve_actuation_priority valve_actuation_priority_assertions chk_i (.hclk, .hresetn, .protective_demand,
  .pos_closed_fb, .module_drive, .solenoid_energized, .valve_open_cmd, .seal_in_active);
`default_nettype wire

// ---- verification/valve_switch_model.sv ----
// Valve with closed-position switches, moved by the two division solenoids
`timescale 1ns/10ps
`default_nettype none
module valve_switch_model (
  input  wire logic       hclk,
  input  wire logic [1:0] solenoid_energized,
  input  wire logic [7:0] stroke,
  output var  logic [1:0] pos_closed_fb
);
  int pos = 0;
  // Opens only with both energized, closes when either drops
  always @(posedge hclk) begin
    if (&solenoid_energized) pos <= (pos > 0) ? pos - 1 : 0;
    else pos <= (pos < stroke) ? pos + 1 : stroke;
  end
  assign pos_closed_fb = {2{pos >= stroke}};
endmodule : valve_switch_model
`default_nettype wire

// ---- verification/valve_actuation_priority_bench.sv ----
// Self-checking bench for the valve actuation priority block
`timescale 1ns/10ps
`default_nettype none
`include "valve_consts.svh"
module valve_actuation_priority_bench;
  logic        hclk, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp, open;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0, protective_demand = 2'h0, nonsafety_enable = 2'h0, fb, sol, seal;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  drive;
  logic [7:0]  stroke = 8'h04;
  logic [13:0] nonsafety_cmd = 14'h0;
  int          mismatches = 0, total_checks = 0, cyc = 0;
  valve_actuation_priority uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .protective_demand, .nonsafety_enable,
    .nonsafety_cmd, .pos_closed_fb(fb), .module_drive(drive), .solenoid_energized(sol),
    .valve_open_cmd(open), .seal_in_active(seal));
  valve_switch_model fbm (.hclk, .solenoid_energized(sol), .stroke, .pos_closed_fb(fb));
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [31:0] a, e);
    bus(1'h0, a, 32'h0);
    chk("hrdata", e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd
  task automatic w(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : w
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    rd(`REG_CTRL, `CTRL_RESET_VAL);
    rd(`REG_STATUS, 32'h0);
    rd(32'h0000_0010, 32'h0);
    $display("test reset done");
    @(posedge hclk) nonsafety_cmd <= 14'h0001;
    w(8);
    chk("open", 1'h0, open);
    @(posedge hclk) nonsafety_enable <= 2'h3;
    w(8);
    chk("drive", 4'hF, drive);
    chk("open", 1'h1, open);
    rd(`REG_NSCMD, 32'h0000_C001);
    $display("test enable done");
    bus(1'h1, `REG_CTRL, 32'h0000_0002);
    w(6);
    chk("drive", 4'hA, drive);
    rd(`REG_STATUS, 32'h0000_01CA);
    bus(1'h1, `REG_CTRL, 32'h0);
    $display("test removal done");
    @(posedge hclk) protective_demand <= 2'h1;
    stroke <= 8'h1E;
    repeat (2) @(posedge hclk);
    protective_demand <= 2'h0;
    w(4);
    chk("drive", 2'h0, drive[1:0]);
    chk("sol", 2'h2, sol);
    chk("open", 1'h0, open);
    chk("seal", 2'h1, seal);
    w(16);
    chk("seal", 2'h1, seal);
    chk("drive", 2'h0, drive[1:0]);
    for (int i = 0; i < 60 && seal[0]; i++) w(1);
    chk("seal", 2'h0, seal);
    $display("test seal done");
    w(8);
    chk("open", 1'h1, open);
    @(posedge hclk) nonsafety_cmd <= 14'h0002;
    w(8);
    chk("drive", 4'h0, drive);
    chk("open", 1'h0, open);
    $display("test close done");
    @(posedge hclk) nonsafety_enable <= 2'h0;
    nonsafety_cmd <= 14'h0001;
    bus(1'h1, `REG_CTRL, 32'h0000_0005);
    w(6);
    chk("drive", 4'h5, drive);
    chk("open", 1'h1, open);
    @(posedge hclk) protective_demand <= 2'h2;
    w(6);
    chk("drive", 4'h1, drive);
    chk("sol", 2'h1, sol);
    chk("open", 1'h0, open);
    chk("seal", 2'h2, seal);
    @(posedge hclk) protective_demand <= 2'h0;
    for (int i = 0; i < 80 && seal[1]; i++) w(1);
    chk("seal", 2'h0, seal);
    w(8);
    chk("drive", 4'h5, drive);
    $display("test division done");
    wrap_up;
  end
endmodule : valve_actuation_priority_bench
`default_nettype wire
